// [core/test_sync_shaper_regs.sv]
// test pattern, self-test signature, sync control and noise shaper register slice
`timescale 1ns/100ps
`default_nettype none

//
// Behaviour
// - Each user test pattern is 16 bits, the lower address holding bits 7 to 0 and the next bits 15 to 8.
// - Sync control bit 0 is the master sync enable and no sync function acts while it is low.
// - Sync control bit 1 passes sync pulses to the clock divider only when it and the master enable are high.
// - Shaper mode 000 selects the 22 percent band and 001 the 33 percent band.
// - A channel's shaper runs when its enable bit is 1 and stops when it is 0, the control reading zero after reset.
// - Each channel keeps a six-bit tuning word in bits 5 to 0, reset to 0x1C, read against the selected mode.
// - Tuning steps are half a percent of the sample rate, with 57 valid words narrow and 34 wide.
// - With both sync enables high every received sync pulse resynchronises the clock divider.
module test_sync_shaper_regs (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // serial control port
   input  wire logic             sclkPin,
   input  wire logic             csbPin,
   input  wire logic             sdioIn,
   output logic                  sdioOut,
   output logic                  sdioOe,
   // channel index from the earlier part of the map, bit 0 channel A, bit 1 channel B
   input  wire logic [1:0]       channelSelect,
   // self-test signatures, read only
   input  wire logic [1:0][15:0] signature,
   // sync input pin
   input  wire logic             syncPin,
   // test pattern outputs
   output logic [15:0]           pattern2,
   output logic [15:0]           pattern3,
   output logic [15:0]           pattern4,
   // sync outputs
   output logic                  syncBufferEnable,
   output logic                  dividerSync,
   // noise shaper outputs per channel
   output logic [1:0]            shaperEnable,
   output logic [1:0][2:0]       shaperMode,
   output logic [1:0]            shaperWide,
   output logic [1:0][5:0]       shaperTuning,
   output logic [1:0]            tuningValid
);

   // ***************************************************
   // helpers
   // ***************************************************
   function automatic logic isWideBand(input logic [2:0] mode);
      // codes other than 001 fall back to the narrow band
      isWideBand = (mode == test_sync_shaper_pkg::MODE_BAND_33);
   endfunction

   // one tuning step is half a percent of the sample rate; the count of steps depends on the band
   function automatic logic wordInRange(input logic [2:0] mode, input logic [5:0] word);
      if (isWideBand(mode)) begin
         wordInRange = (word < test_sync_shaper_pkg::WORDS_BAND_33);
      end else begin
         wordInRange = (word < test_sync_shaper_pkg::WORDS_BAND_22);
      end
   endfunction

   function automatic int unsigned readChannel(input logic [1:0] sel);
      readChannel = sel[0] ? 0 : 1;
   endfunction

   // ***************************************************
   // serial port
   // ***************************************************
   logic [12:0] addr;
   logic        wrStrobe;
   logic [7:0]  wrData;
   logic [7:0]  rdData;

   serial_port_engine u_engine (
      .clk      (clk),
      .reset_n  (reset_n),
      .sclkPin  (sclkPin),
      .csbPin   (csbPin),
      .sdioIn   (sdioIn),
      .sdioOut  (sdioOut),
      .sdioOe   (sdioOe),
      .rdData   (rdData),
      .addr     (addr),
      .wrStrobe (wrStrobe),
      .wrData   (wrData)
   );

   // ***************************************************
   // state
   // ***************************************************
   test_sync_shaper_pkg::regs_t q;
   test_sync_shaper_pkg::regs_t d;

   // ***************************************************
   // read mux
   // ***************************************************
   always_comb begin
      int unsigned ch;
      ch = readChannel(channelSelect);
      rdData = 8'h00;
      case (addr)
         test_sync_shaper_pkg::ADDR_PATTERN2_LOW: begin
            rdData = q.pattern2[7:0];
         end
         test_sync_shaper_pkg::ADDR_PATTERN2_HIGH: begin
            rdData = q.pattern2[15:8];
         end
         test_sync_shaper_pkg::ADDR_PATTERN3_LOW: begin
            rdData = q.pattern3[7:0];
         end
         test_sync_shaper_pkg::ADDR_PATTERN3_HIGH: begin
            rdData = q.pattern3[15:8];
         end
         test_sync_shaper_pkg::ADDR_PATTERN4_LOW: begin
            rdData = q.pattern4[7:0];
         end
         test_sync_shaper_pkg::ADDR_PATTERN4_HIGH: begin
            rdData = q.pattern4[15:8];
         end
         test_sync_shaper_pkg::ADDR_SIGNATURE_LOW: begin
            rdData = signature[ch][7:0];
         end
         test_sync_shaper_pkg::ADDR_SIGNATURE_HIGH: begin
            rdData = signature[ch][15:8];
         end
         test_sync_shaper_pkg::ADDR_SYNC_CONTROL: begin
            rdData = {6'h00, q.syncCtrl};
         end
         test_sync_shaper_pkg::ADDR_SHAPER_CONTROL: begin
            rdData = {4'h0, q.shaperMode[ch], q.shaperEnable[ch]};
         end
         test_sync_shaper_pkg::ADDR_SHAPER_TUNING: begin
            rdData = {2'h0, q.shaperTuning[ch]};
         end
         default: begin
            rdData = 8'h00;
         end
      endcase
   end

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      logic syncRise;
      syncRise = 1'b0;
      d = q;
      if (wrStrobe) begin
         case (addr)
            test_sync_shaper_pkg::ADDR_PATTERN2_LOW: begin
               d.pattern2[7:0] = wrData;
            end
            test_sync_shaper_pkg::ADDR_PATTERN2_HIGH: begin
               d.pattern2[15:8] = wrData;
            end
            test_sync_shaper_pkg::ADDR_PATTERN3_LOW: begin
               d.pattern3[7:0] = wrData;
            end
            test_sync_shaper_pkg::ADDR_PATTERN3_HIGH: begin
               d.pattern3[15:8] = wrData;
            end
            test_sync_shaper_pkg::ADDR_PATTERN4_LOW: begin
               d.pattern4[7:0] = wrData;
            end
            test_sync_shaper_pkg::ADDR_PATTERN4_HIGH: begin
               d.pattern4[15:8] = wrData;
            end
            test_sync_shaper_pkg::ADDR_SYNC_CONTROL: begin
               d.syncCtrl = wrData[1:0];
            end
            test_sync_shaper_pkg::ADDR_SHAPER_CONTROL: begin
               // per-channel writes land in every channel the index selects
               for (int c = 0; c < 2; c++) begin
                  if (channelSelect[c]) begin
                     d.shaperEnable[c] = wrData[test_sync_shaper_pkg::SHAPER_ENABLE_POS];
                     d.shaperMode[c] = wrData[test_sync_shaper_pkg::SHAPER_MODE_MSB:
                                              test_sync_shaper_pkg::SHAPER_MODE_LSB];
                  end
               end
            end
            test_sync_shaper_pkg::ADDR_SHAPER_TUNING: begin
               for (int c = 0; c < 2; c++) begin
                  if (channelSelect[c]) begin
                     d.shaperTuning[c] = wrData[test_sync_shaper_pkg::TUNING_MSB:0];
                  end
               end
            end
            default: begin
               d.syncCtrl = q.syncCtrl;
            end
         endcase
      end
      // derived flags follow the stored fields one cycle later
      for (int c = 0; c < 2; c++) begin
         d.shaperWide[c] = isWideBand(q.shaperMode[c]);
         d.tuningValid[c] = wordInRange(q.shaperMode[c], q.shaperTuning[c]);
      end
      // sync pin, three flops, level taken once the last two agree
      d.syncPinSync = {q.syncPinSync[1:0], syncPin};
      if (q.syncPinSync[1] == q.syncPinSync[2]) begin
         d.syncLevel = q.syncPinSync[2];
      end
      syncRise = d.syncLevel & ~q.syncLevel;
      // low master enable also powers the sync buffer down
      d.syncBufferEnable = q.syncCtrl[test_sync_shaper_pkg::SYNC_MASTER_POS];
      d.dividerSync = syncRise
                    & q.syncCtrl[test_sync_shaper_pkg::SYNC_MASTER_POS]
                    & q.syncCtrl[test_sync_shaper_pkg::SYNC_DIVIDER_POS];
   end

   // ***************************************************
   // registers
   // ***************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q.pattern2 <= test_sync_shaper_pkg::PATTERN_RESET;
         q.pattern3 <= test_sync_shaper_pkg::PATTERN_RESET;
         q.pattern4 <= test_sync_shaper_pkg::PATTERN_RESET;
         q.syncCtrl <= test_sync_shaper_pkg::SYNC_RESET;
         q.shaperEnable <= {2{test_sync_shaper_pkg::ENABLE_RESET}};
         q.shaperMode <= {2{test_sync_shaper_pkg::MODE_RESET}};
         q.shaperTuning <= {2{test_sync_shaper_pkg::TUNING_RESET}};
         q.shaperWide <= 2'h0;
         q.tuningValid <= 2'h3;
         q.syncPinSync <= 3'h0;
         q.syncLevel <= 1'b0;
         q.dividerSync <= 1'b0;
         q.syncBufferEnable <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign pattern2 = q.pattern2;
   assign pattern3 = q.pattern3;
   assign pattern4 = q.pattern4;
   assign syncBufferEnable = q.syncBufferEnable;
   assign dividerSync = q.dividerSync;
   assign shaperEnable = q.shaperEnable;
   assign shaperMode = q.shaperMode;
   assign shaperWide = q.shaperWide;
   assign shaperTuning = q.shaperTuning;
   assign tuningValid = q.tuningValid;

endmodule

`default_nettype wire

// [common/test_sync_shaper_pkg.sv]
// shared constants and state types of the test pattern, sync and noise shaper register slice
`default_nettype none
package test_sync_shaper_pkg;

   // ***************************************************
   // serial frame layout
   // ***************************************************
   localparam int unsigned INSTR_BITS   = 16;
   localparam int unsigned FRAME_BITS   = 24;
   localparam logic [4:0]  INSTR_LAST   = 5'h0F;
   localparam logic [4:0]  FRAME_LAST   = 5'h17;
   localparam logic [4:0]  DATA_FIRST   = 5'h10;
   localparam int unsigned RW_POS       = 14;
   localparam int unsigned ADDR_WIDTH   = 13;

   // ***************************************************
   // register addresses
   // ***************************************************
   localparam logic [12:0] ADDR_PATTERN2_LOW    = 13'h001B;
   localparam logic [12:0] ADDR_PATTERN2_HIGH   = 13'h001C;
   localparam logic [12:0] ADDR_PATTERN3_LOW    = 13'h001D;
   localparam logic [12:0] ADDR_PATTERN3_HIGH   = 13'h001E;
   localparam logic [12:0] ADDR_PATTERN4_LOW    = 13'h001F;
   localparam logic [12:0] ADDR_PATTERN4_HIGH   = 13'h0020;
   localparam logic [12:0] ADDR_SIGNATURE_LOW   = 13'h0024;
   localparam logic [12:0] ADDR_SIGNATURE_HIGH  = 13'h0025;
   localparam logic [12:0] ADDR_SYNC_CONTROL    = 13'h003A;
   localparam logic [12:0] ADDR_SHAPER_CONTROL  = 13'h003C;
   localparam logic [12:0] ADDR_SHAPER_TUNING   = 13'h003E;

   // ***************************************************
   // field positions
   // ***************************************************
   localparam int unsigned SYNC_MASTER_POS   = 0;
   localparam int unsigned SYNC_DIVIDER_POS  = 1;
   localparam int unsigned SHAPER_ENABLE_POS = 0;
   localparam int unsigned SHAPER_MODE_LSB   = 1;
   localparam int unsigned SHAPER_MODE_MSB   = 3;
   localparam int unsigned TUNING_MSB        = 5;

   // ***************************************************
   // reset values and encodings
   // ***************************************************
   localparam logic [15:0] PATTERN_RESET     = 16'h0000;
   localparam logic [1:0]  SYNC_RESET        = 2'h0;
   localparam logic [2:0]  MODE_RESET        = 3'h0;
   localparam logic        ENABLE_RESET      = 1'h0;
   localparam logic [5:0]  TUNING_RESET      = 6'h1C;
   localparam logic [2:0]  MODE_BAND_22      = 3'h0;
   localparam logic [2:0]  MODE_BAND_33      = 3'h1;
   localparam logic [5:0]  WORDS_BAND_22     = 6'h39;
   localparam logic [5:0]  WORDS_BAND_33     = 6'h22;

   // ***************************************************
   // state of the serial port engine
   // ***************************************************
   typedef struct packed {
      logic [2:0]  sclkSync;
      logic [2:0]  csbSync;
      logic [2:0]  sdiSync;
      logic        sclkLevel;
      logic        csbLevel;
      logic        sdiLevel;
      logic [4:0]  bitCnt;
      logic [14:0] shift;
      logic        isRead;
      logic [12:0] addr;
      logic        rdLoad;
      logic        nextByte;
      logic [7:0]  dout;
      logic        wrStrobe;
      logic [7:0]  wrData;
      logic        sdioOut;
      logic        sdioOe;
   } engine_t;

   // ***************************************************
   // state of the register slice
   // ***************************************************
   typedef struct packed {
      logic [15:0]      pattern2;
      logic [15:0]      pattern3;
      logic [15:0]      pattern4;
      logic [1:0]       syncCtrl;
      logic [1:0]       shaperEnable;
      logic [1:0][2:0]  shaperMode;
      logic [1:0][5:0]  shaperTuning;
      logic [1:0]       shaperWide;
      logic [1:0]       tuningValid;
      logic [2:0]       syncPinSync;
      logic             syncLevel;
      logic             dividerSync;
      logic             syncBufferEnable;
   } regs_t;

endpackage

`default_nettype wire

// [core/serial_port_engine.sv]
// serial control port engine: 16-bit instruction, byte data, address steps down in streaming
`timescale 1ns/100ps
`default_nettype none

module serial_port_engine (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // serial pins
   input  wire logic        sclkPin,
   input  wire logic        csbPin,
   input  wire logic        sdioIn,
   output logic             sdioOut,
   output logic             sdioOe,
   // register side
   input  wire logic [7:0]  rdData,
   output logic [12:0]      addr,
   output logic             wrStrobe,
   output logic [7:0]       wrData
);

   // ***************************************************
   // state
   // ***************************************************
   test_sync_shaper_pkg::engine_t q;
   test_sync_shaper_pkg::engine_t d;

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      logic rise;
      logic fall;
      rise = 1'b0;
      fall = 1'b0;
      d = q;
      d.wrStrobe = 1'b0;
      d.rdLoad = 1'b0;
      d.nextByte = 1'b0;
      // pins pass three flops; a level counts once the last two agree
      d.sclkSync = {q.sclkSync[1:0], sclkPin};
      d.csbSync = {q.csbSync[1:0], csbPin};
      d.sdiSync = {q.sdiSync[1:0], sdioIn};
      if (q.sclkSync[1] == q.sclkSync[2]) begin
         d.sclkLevel = q.sclkSync[2];
      end
      if (q.csbSync[1] == q.csbSync[2]) begin
         d.csbLevel = q.csbSync[2];
      end
      if (q.sdiSync[1] == q.sdiSync[2]) begin
         d.sdiLevel = q.sdiSync[2];
      end
      rise = d.sclkLevel & ~q.sclkLevel;
      fall = ~d.sclkLevel & q.sclkLevel;
      if (q.rdLoad) begin
         d.dout = rdData;
      end
      if (q.nextByte) begin
         d.addr = q.addr - 13'h0001;
         d.rdLoad = q.isRead;
      end
      if (q.csbLevel) begin
         d.bitCnt = 5'h00;
         d.sdioOe = 1'b0;
         d.sdioOut = 1'b0;
      end else if (rise) begin
         d.shift = {q.shift[13:0], d.sdiLevel};
         if (q.bitCnt == test_sync_shaper_pkg::INSTR_LAST) begin
            d.isRead = q.shift[test_sync_shaper_pkg::RW_POS];
            d.addr = {q.shift[11:0], d.sdiLevel};
            d.rdLoad = q.shift[test_sync_shaper_pkg::RW_POS];
            d.bitCnt = q.bitCnt + 5'h01;
         end else if (q.bitCnt == test_sync_shaper_pkg::FRAME_LAST) begin
            d.wrStrobe = ~q.isRead;
            d.wrData = {q.shift[6:0], d.sdiLevel};
            d.nextByte = 1'b1;
            d.bitCnt = test_sync_shaper_pkg::DATA_FIRST;
         end else begin
            d.bitCnt = q.bitCnt + 5'h01;
         end
      end else if (fall && q.isRead && (q.bitCnt >= test_sync_shaper_pkg::DATA_FIRST)) begin
         // read data leaves on falling edges so the host samples it on rising ones
         d.sdioOe = 1'b1;
         d.sdioOut = q.dout[7];
         d.dout = {q.dout[6:0], 1'b0};
      end
   end

   // ***************************************************
   // registers
   // ***************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
         q.sclkSync <= 3'h0;
         q.csbSync <= 3'h7;
         q.csbLevel <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign sdioOut = q.sdioOut;
   assign sdioOe = q.sdioOe;
   assign addr = q.addr;
   assign wrStrobe = q.wrStrobe;
   assign wrData = q.wrData;

endmodule

`default_nettype wire

// [bench/test_sync_shaper_regs_chk.sv]
// port assertions of the register slice
`timescale 1ns/100ps
`default_nettype none

module test_sync_shaper_regs_chk (
   input  wire logic            clk,
   input  wire logic            reset_n,
   input  wire logic            csbPin,
   input  wire logic            syncPin,
   input  wire logic [15:0]     pattern2,
   input  wire logic [15:0]     pattern3,
   input  wire logic [15:0]     pattern4,
   input  wire logic            syncBufferEnable,
   input  wire logic            dividerSync,
   input  wire logic [1:0]      shaperEnable,
   input  wire logic [1:0][2:0] shaperMode,
   input  wire logic [1:0]      shaperWide,
   input  wire logic [1:0][5:0] shaperTuning,
   input  wire logic [1:0]      tuningValid
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   property p_reset_values;
      $rose(reset_n) |-> {pattern2, pattern3, pattern4} == 48'h0 && shaperTuning == 12'h71C && shaperEnable == 2'h0;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("reset value wrong");
   property p_wide_follows_mode;
      shaperWide == {$past(shaperMode[1]) == test_sync_shaper_pkg::MODE_BAND_33,
                     $past(shaperMode[0]) == test_sync_shaper_pkg::MODE_BAND_33};
   endproperty
   a_wide_follows_mode: assert property (p_wide_follows_mode) else $error("band select wrong");
   property p_valid_limit;
      tuningValid[0] == (($past(shaperMode[0]) == test_sync_shaper_pkg::MODE_BAND_33)
         ? ($past(shaperTuning[0]) < test_sync_shaper_pkg::WORDS_BAND_33)
         : ($past(shaperTuning[0]) < test_sync_shaper_pkg::WORDS_BAND_22));
   endproperty
   a_valid_limit: assert property (p_valid_limit) else $error("tuning validity wrong");
   property p_divider_master;
      dividerSync |-> syncBufferEnable;
   endproperty
   a_divider_master: assert property (p_divider_master) else $error("sync without master enable");
   property p_divider_source;
      dividerSync |-> $past(syncPin, 3) && !$past(syncPin, 7);
   endproperty
   a_divider_source: assert property (p_divider_source) else $error("sync pulse without pin edge");
   property p_divider_pulse;
      dividerSync |=> !dividerSync;
   endproperty
   a_divider_pulse: assert property (p_divider_pulse) else $error("sync pulse too long");
   property p_patterns_in_frame;
      $changed({pattern2, pattern3, pattern4}) |-> !$past(csbPin);
   endproperty
   a_patterns_in_frame: assert property (p_patterns_in_frame) else $error("pattern changed idle");
   property p_shaper_in_frame;
      $changed({shaperEnable, shaperMode, shaperTuning}) |-> !$past(csbPin);
   endproperty
   a_shaper_in_frame: assert property (p_shaper_in_frame) else $error("shaper changed idle");

   c_divider: cover property (dividerSync);
   c_wide: cover property (shaperWide[0]);
   c_invalid: cover property (!tuningValid[0]);
endmodule

bind test_sync_shaper_regs test_sync_shaper_regs_chk i_chk (.clk, .reset_n, .csbPin, .syncPin, .pattern2, .pattern3,
   .pattern4, .syncBufferEnable, .dividerSync, .shaperEnable, .shaperMode, .shaperWide, .shaperTuning, .tuningValid);

`default_nettype wire

// [bench/host_model.sv]
// host controller model of the serial control port
`timescale 1ns/100ps
`default_nettype none

module host_model #(
   parameter int HALF = 8
) (
   input  wire logic clk,
   input  wire logic sdioOut,
   input  wire logic sdioOe,
   output logic      sclkPin,
   output logic      csbPin,
   output logic      sdioIn
);
   initial begin
      sclkPin = 1'b0;
      csbPin = 1'b1;
      sdioIn = 1'b0;
   end

   // one frame, instruction then nb bytes (high byte of wd first); sclk stands low between frames
   task automatic xfer(input logic rw, input logic [12:0] a, input logic [15:0] wd, input int nb,
                       output logic [7:0] rd);
      logic [31:0] f;
      f = {rw, 2'b00, a, wd};
      rd = 8'h00;
      @(negedge clk);
      csbPin = 1'b0;
      for (int i = 31; i >= 16 - 8 * nb; i--) begin
         // data line not ours during read data, so it toggles
         sdioIn = (rw && i < 16) ? ~sdioIn : f[i];
         repeat (HALF) @(negedge clk);
         sclkPin = 1'b1;
         // undriven line shows the inverse, so a missing output enable is caught
         if (i < 24 - 8 * nb)
            rd = {rd[6:0], sdioOe ? sdioOut : ~sdioOut};
         repeat (HALF) @(negedge clk);
         sclkPin = 1'b0;
      end
      repeat (HALF) @(negedge clk);
      csbPin = 1'b1;
      sdioIn = ~sdioIn;
      repeat (HALF) @(negedge clk);
   endtask
endmodule

`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench of the register slice
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   logic             clk, reset_n, sclkPin, csbPin, sdioIn, sdioOut, sdioOe;
   logic             syncPin, syncBufferEnable, dividerSync;
   logic [1:0]       channelSelect, shaperEnable, shaperWide, tuningValid;
   logic [1:0][15:0] signature;
   logic [15:0]      pattern2, pattern3, pattern4;
   logic [1:0][2:0]  shaperMode;
   logic [1:0][5:0]  shaperTuning;
   logic [7:0]       rdByte;
   int               miscompares, checks, pulses;
   int               addrs [12] = '{'h1B, 'h1C, 'h1D, 'h1E, 'h1F, 'h20, 'h24, 'h25, 'h3A, 'h3C, 'h3E, 'h21};
   int               vals [12] = '{0, 0, 0, 0, 0, 0, 'hC3, 'hA5, 0, 0, 'h1C, 0};
   logic [7:0]       tune [5] = '{8'h21, 8'h22, 8'h38, 8'h39, 8'hFF};

   test_sync_shaper_regs i_dut (.clk, .reset_n, .sclkPin, .csbPin, .sdioIn, .sdioOut, .sdioOe, .channelSelect,
      .signature, .syncPin, .pattern2, .pattern3, .pattern4, .syncBufferEnable, .dividerSync, .shaperEnable,
      .shaperMode, .shaperWide, .shaperTuning, .tuningValid);
   host_model i_host (.clk, .sdioOut, .sdioOe, .sclkPin, .csbPin, .sdioIn);

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(negedge clk) if (dividerSync === 1'b1) pulses++;

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      i_host.xfer(1'b0, a, {d, 8'h00}, 1, rdByte);
   endtask
   task automatic rd(input logic [12:0] a, input logic [7:0] exp);
      i_host.xfer(1'b1, a, 16'h0000, 1, rdByte);
      check({8'h00, rdByte}, {8'h00, exp});
   endtask
   task automatic fire(input int n, input int exp);
      pulses = 0;
      repeat (n) begin
         @(negedge clk) syncPin = 1'b1;
         repeat (10) @(negedge clk);
         syncPin = 1'b0;
         repeat (10) @(negedge clk);
      end
      check(16'(pulses), 16'(exp));
   endtask
   task automatic doReset();
      reset_n = 1'b0;
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      repeat (5) @(negedge clk);
   endtask
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #1_500_000;
      miscompares++;
      wrap_up();
   end

   initial begin
      reset_n = 1'b0;
      syncPin = 1'b0;
      channelSelect = 2'b11;
      signature = {16'h5A3C, 16'hA5C3};
      miscompares = 0;
      checks = 0;
      pulses = 0;
      // ***************************************************
      // reset values
      // ***************************************************
      doReset();
      foreach (addrs[k]) rd(13'(addrs[k]), 8'(vals[k]));
      check({4'h0, shaperTuning}, 16'h071C);
      check({14'h0, shaperEnable}, 16'h0000);
      $display("test reset done");
      // ***************************************************
      // user patterns and read-only places
      // ***************************************************
      for (int k = 0; k < 6; k++) wr(13'('h1B + k), 8'(8'h11 * (k + 1)));
      check(pattern2, 16'h2211);
      check(pattern3, 16'h4433);
      check(pattern4, 16'h6655);
      for (int k = 0; k < 6; k++) rd(13'('h1B + k), 8'(8'h11 * (k + 1)));
      // two bytes in one frame, address stepping down from the high half
      i_host.xfer(1'b0, test_sync_shaper_pkg::ADDR_PATTERN3_HIGH, 16'hBEEF, 2, rdByte);
      check(pattern3, 16'hBEEF);
      rd(test_sync_shaper_pkg::ADDR_PATTERN3_LOW, 8'hEF);
      wr(test_sync_shaper_pkg::ADDR_SIGNATURE_LOW, 8'hFF);
      rd(test_sync_shaper_pkg::ADDR_SIGNATURE_LOW, 8'hC3);
      wr(13'h0022, 8'hFF);
      rd(13'h0022, 8'h00);
      $display("test patterns done");
      // ***************************************************
      // sync gating
      // ***************************************************
      fire(1, 0);
      wr(test_sync_shaper_pkg::ADDR_SYNC_CONTROL, 8'hFF);
      rd(test_sync_shaper_pkg::ADDR_SYNC_CONTROL, 8'h03);
      check({15'h0, syncBufferEnable}, 16'h0001);
      fire(3, 3);
      wr(test_sync_shaper_pkg::ADDR_SYNC_CONTROL, 8'h01);
      fire(1, 0);
      wr(test_sync_shaper_pkg::ADDR_SYNC_CONTROL, 8'h02);
      check({15'h0, syncBufferEnable}, 16'h0000);
      fire(1, 0);
      $display("test sync done");
      // ***************************************************
      // noise shaper per channel
      // ***************************************************
      channelSelect = 2'b01;
      wr(test_sync_shaper_pkg::ADDR_SHAPER_CONTROL, 8'h03);
      check({14'h0, shaperEnable}, 16'h0001);
      check({10'h0, shaperMode}, 16'h0001);
      check({14'h0, shaperWide}, 16'h0001);
      channelSelect = 2'b10;
      // unlisted mode code on channel b, which falls back to the narrow band
      wr(test_sync_shaper_pkg::ADDR_SHAPER_CONTROL, 8'hF5);
      rd(test_sync_shaper_pkg::ADDR_SHAPER_CONTROL, 8'h05);
      check({14'h0, shaperEnable}, 16'h0003);
      check({10'h0, shaperMode}, 16'h0011);
      check({14'h0, shaperWide}, 16'h0001);
      rd(test_sync_shaper_pkg::ADDR_SIGNATURE_LOW, 8'h3C);
      rd(test_sync_shaper_pkg::ADDR_SIGNATURE_HIGH, 8'h5A);
      // both channels addressed, as kept whenever address zero is written
      channelSelect = 2'b11;
      foreach (tune[k]) begin
         wr(test_sync_shaper_pkg::ADDR_SHAPER_TUNING, tune[k]);
         check({4'h0, shaperTuning}, {4'h0, tune[k][5:0], tune[k][5:0]});
         check({14'h0, tuningValid}, {14'h0, tune[k][5:0] < 6'h39, tune[k][5:0] < 6'h22});
         rd(test_sync_shaper_pkg::ADDR_SHAPER_TUNING, tune[k] & 8'h3F);
      end
      channelSelect = 2'b01;
      wr(test_sync_shaper_pkg::ADDR_SHAPER_CONTROL, 8'h00);
      check({14'h0, shaperEnable}, 16'h0002);
      $display("test shaper done");
      // ***************************************************
      // reset in mid-run
      // ***************************************************
      doReset();
      rd(test_sync_shaper_pkg::ADDR_SHAPER_TUNING, 8'h1C);
      check(pattern3, 16'h0000);
      $display("test second reset done");
      wrap_up();
   end
endmodule

`default_nettype wire
